// >>> verilog/amc_pkg.sv
/*
 * Shared constants for the ten-cell asynchronous-register output macrocell
 * array: cell and input counts, product-term layout, reset values.
 * Assumes a single 250 MHz clock domain and fuse inputs held steady.
 */
package amc_pkg;

    localparam int NUM_CELLS      = 10;
    localparam int NUM_INPUTS     = 10;
    localparam int LOGIC_TERMS    = 4;
    localparam int TERMS_PER_CELL = 8;
    // Term slots within one cell
    localparam int TERM_LOGIC0    = 0;
    localparam int TERM_RESET     = 4;
    localparam int TERM_PRESET    = 5;
    localparam int TERM_CLOCK     = 6;
    localparam int TERM_OE        = 7;
    // Array signals: dedicated inputs, pin feedback, flip-flop feedback
    localparam int NUM_SIGNALS    = NUM_INPUTS + 2 * NUM_CELLS;
    localparam int NUM_LITERALS   = 2 * NUM_SIGNALS;
    localparam int FUSE_WIDTH     = NUM_CELLS * TERMS_PER_CELL
                                    * NUM_LITERALS;
    localparam int SYNC_STAGES    = 2;
    // Reset values
    localparam logic FF_RESET_VAL  = 1'b0;
    localparam logic OUT_RESET_VAL = 1'b0;
    localparam logic OE_RESET_VAL  = 1'b0;

endpackage

// >>> verilog/amc_output_macrocells.sv
/*
 * Ten output_macrocell cells behind ten two-way pins, fed by a
 * programmable AND array over ten dedicated inputs and all feedbacks.
 * Assumes fuse, polarity and bypass inputs are static configuration on
 * clk_i; pins arrive asynchronously and are synchronised here.
 */
// How it works
// R1: Ten dedicated inputs, ten two-way pins, one macrocell per pin.
// R2: Each cell flip-flop has own reset, preset and clock product terms.
// R3: D input is OR of four logic terms through a polarity XNOR.
// R4: Pin driven only when cell OE term true and shared OE pin active.
// R5: Per-cell bypass picks registered or combinational output, any mix.
// R6: Flip-flop captures only on rising edge of its own clock term.
// R7: Up to ten clocks, from any input pins and flip-flop feedback.
// R8: Any logic term true gives D equal to the polarity bit.
// R9: Reset, preset and preload ignore the polarity bit.
// R10: No logic term true gives D opposite to the polarity bit.
// R11: Reset and preset together resolve to reset.
module amc_output_macrocells
    import amc_pkg::*;
#(
    parameter int CELLS  = amc_pkg::NUM_CELLS,
    parameter int INPUTS = amc_pkg::NUM_INPUTS
)
(
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire logic                          ce_i,
    input  wire logic [amc_pkg::NUM_INPUTS-1:0] in_i,
    input  wire logic [amc_pkg::NUM_CELLS-1:0]  io_in_i,
    output logic      [amc_pkg::NUM_CELLS-1:0]  io_out_o,
    output logic      [amc_pkg::NUM_CELLS-1:0]  io_oe_o,
    input  wire logic                          oe_pin_n_i,
    input  wire logic                          preload_i,
    input  wire logic [amc_pkg::NUM_CELLS-1:0]  preload_data_i,
    input  wire logic [amc_pkg::FUSE_WIDTH-1:0] fuse_i,
    input  wire logic [amc_pkg::NUM_CELLS-1:0]  pol_i,
    input  wire logic [amc_pkg::NUM_CELLS-1:0]  bypass_i
);
    import amc_pkg::*;

    // Dedicated inputs, pins, preload data, preload strobe, shared enable
    localparam int SYNC_W = NUM_INPUTS + 2 * NUM_CELLS + 2;

    // Two-stage synchroniser for every asynchronous pin
    logic [SYNC_W-1:0]       sync1_q;
    logic [SYNC_W-1:0]       sync2_q;

    // Synchronised pin fields
    logic [NUM_INPUTS-1:0]   in_s;
    logic [NUM_CELLS-1:0]    io_s;
    logic [NUM_CELLS-1:0]    pre_data_s;
    logic                    oe_pin_n_s;
    logic                    preload_s;

    // Array inputs
    logic [NUM_SIGNALS-1:0]  sig;
    logic [NUM_LITERALS-1:0] lits;

    // Per-cell state, one bit per macrocell
    logic [NUM_CELLS-1:0]    ff_q;
    logic [NUM_CELLS-1:0]    clk_term_q;
    logic [NUM_CELLS-1:0]    out_q;
    logic [NUM_CELLS-1:0]    oe_q;

    // Pins are asynchronous; first stage feeds only the second
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_q <= '0;
        end
        else if (ce_i)
        begin
            sync1_q <= {oe_pin_n_i,
                        preload_i,
                        preload_data_i,
                        io_in_i,
                        in_i};
        end
    end

    // Second stage is the only reader of the first
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync2_q <= '0;
        end
        else if (ce_i)
        begin
            sync2_q <= sync1_q;
        end
    end

    assign in_s       = sync2_q[NUM_INPUTS-1:0];
    assign io_s       = sync2_q[NUM_INPUTS +: NUM_CELLS];
    assign pre_data_s = sync2_q[NUM_INPUTS+NUM_CELLS +: NUM_CELLS];
    assign preload_s  = sync2_q[SYNC_W-2];
    assign oe_pin_n_s = sync2_q[SYNC_W-1];

    // True and complement of every array signal, flip-flop feedback too
    assign sig  = {ff_q, io_s, in_s}; // [R7]
    assign lits = {~sig, sig};

    // One macrocell per two-way pin
    genvar c;
    genvar t;
    generate
        for (c = 0; c < NUM_CELLS; c++)
        begin : g_cell
            logic [TERMS_PER_CELL-1:0] term;
            logic                      sum;
            logic                      d;
            logic                      clk_rise;
            logic                      term_rst;
            logic                      term_pre;
            logic                      term_clk;
            logic                      term_oe;
            logic                      ff_d;

            // A set fuse connects a literal; an empty term reads true
            for (t = 0; t < TERMS_PER_CELL; t++)
            begin : g_term
                assign term[t] = &(~fuse_i[(c*TERMS_PER_CELL+t)*NUM_LITERALS
                                           +: NUM_LITERALS] | lits); // [R2]
            end

            // Four logic terms summed; the rest are control terms
            assign sum = |term[TERM_LOGIC0 +: LOGIC_TERMS]; // [R3]
            // Term true gives pol, none true gives its inverse
            assign d = ~(sum ^ pol_i[c]); // [R3] [R8] [R10]
            // Control terms by name, so the priority below reads plainly
            assign term_rst = term[TERM_RESET];  // [R2]
            assign term_pre = term[TERM_PRESET]; // [R2]
            assign term_clk = term[TERM_CLOCK];  // [R2] [R7]
            assign term_oe  = term[TERM_OE];     // [R4]

            // Edge found by sampling, so a term pulse under 4 ns is lost
            assign clk_rise = term_clk & ~clk_term_q[c]; // [R6]

            // Last cycle's clock term, for edge detection
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    clk_term_q[c] <= 1'b0;
                end
                else if (ce_i)
                begin
                    clk_term_q[c] <= term[TERM_CLOCK];
                end
            end

            // Reset beats preset beats preload beats a clock edge
            always_comb
            begin
                ff_d = ff_q[c];
                if (term_rst)
                begin
                    ff_d = 1'b0; // [R2] [R9] [R11]
                end
                else if (term_pre)
                begin
                    ff_d = 1'b1; // [R2] [R9]
                end
                else if (preload_s)
                begin
                    ff_d = pre_data_s[c]; // [R9]
                end
                else if (clk_rise)
                begin
                    ff_d = d; // [R6]
                end
            end

            // Flip-flop state is held while ce_i is low
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    ff_q[c] <= FF_RESET_VAL;
                end
                else if (ce_i)
                begin
                    ff_q[c] <= ff_d;
                end
            end

            // Outputs registered, so the bypass path lags by one cycle
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    out_q[c] <= OUT_RESET_VAL;
                end
                else if (ce_i)
                begin
                    out_q[c] <= bypass_i[c] ? d : ff_q[c]; // [R5]
                end
            end

            // Shared pin is active low; either source alone turns it off
            always_ff @(posedge clk_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    oe_q[c] <= OE_RESET_VAL;
                end
                else if (ce_i)
                begin
                    oe_q[c] <= term_oe & ~oe_pin_n_s; // [R4]
                end
            end
        end
    endgenerate

    // Outputs come straight from their flip-flops
    assign io_out_o = out_q; // [R1]
    assign io_oe_o  = oe_q;  // [R4]

endmodule

// >>> verification/amc_pin_model.sv
/* Pin wire model for the two-way pins.
   Assumes no pull: a released pin toggles so it never reads stale. */
module amc_pin_model
    import amc_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire logic [amc_pkg::NUM_CELLS-1:0] drv_i,
    input  wire logic [amc_pkg::NUM_CELLS-1:0] oe_i,
    output logic      [amc_pkg::NUM_CELLS-1:0] pin_o
);
    logic [NUM_CELLS-1:0] last_q;
    assign pin_o = (oe_i & drv_i) | (~oe_i & ~last_q);
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            last_q <= '0;
        else
            last_q <= pin_o;
    end
endmodule

// >>> verification/amc_output_macrocells_sva.sv
/* Checker for the macrocell array ports.
   Assumes the bench map: cell 0 bypass, cell 1 clocked, cell 2 set/clear. */
module amc_mc_sva
    import amc_pkg::*;
(
    input wire logic                           clk_i,
    input wire logic                           rstn_i,
    input wire logic                           ce_i,
    input wire logic                           preload_i,
    input wire logic [amc_pkg::NUM_CELLS-1:0]  preload_data_i,
    input wire logic                           oe_pin_n_i,
    input wire logic [amc_pkg::NUM_INPUTS-1:0] in_i,
    input wire logic [amc_pkg::NUM_CELLS-1:0]  io_out_o,
    input wire logic [amc_pkg::NUM_CELLS-1:0]  io_oe_o
);
    logic [3:0] idle_q;
    default clocking cb @(posedge clk_i);
    endclocking
    // Frozen cycles would stretch every delay, so they are left out
    default disable iff (!rstn_i || !ce_i);
    // Saturates so a long quiet spell cannot wrap to a fake recent edge
    always_ff @(posedge clk_i or negedge rstn_i)
        if (!rstn_i)
            idle_q <= 4'hf;
        else if (in_i[1])
            idle_q <= 4'h0;
        else if (idle_q != 4'hf)
            idle_q <= idle_q + 4'h1;
    comb_rise_a: assert property (
        $rose(in_i[0]) |-> ##[1:4] io_out_o[0])
        else $error("cell 0 missed high");
    comb_fall_a: assert property (
        $fell(in_i[0]) |-> ##[1:4] !io_out_o[0])
        else $error("cell 0 missed low");
    own_clock_a: assert property (
        $changed(io_out_o[1]) |-> idle_q < 4'h8)
        else $error("cell 1 moved without its clock");
    no_clock_a: assert property (
        io_out_o[9:3] == 7'h00)
        else $error("unclocked cell moved");
    reset_wins_a: assert property (
        in_i[2] [*6] |-> !io_out_o[2])
        else $error("cell 2 not cleared");
    preset_set_a: assert property (
        (in_i[3] && !in_i[2]) [*6] |-> io_out_o[2])
        else $error("cell 2 not set");
    preload_set_a: assert property (
        (preload_i && preload_data_i[2] && !in_i[2] && !in_i[3]) [*6]
        |-> io_out_o[2])
        else $error("cell 2 not preloaded");
    oe_off_a: assert property (
        oe_pin_n_i [*5] |-> io_oe_o == 10'h000)
        else $error("pin driven while disabled");
    oe_on_a: assert property (
        (!oe_pin_n_i) [*5] |-> io_oe_o == 10'h007)
        else $error("enable mask wrong");
    cover property ($rose(io_out_o[1]));
    cover property ($rose(io_out_o[2]));
    cover property ($fell(io_oe_o[0]));
    cover property (preload_i && io_out_o[2]);
endmodule
bind amc_output_macrocells amc_mc_sva u_amc_mc_sva (.clk_i, .rstn_i,
    .ce_i, .preload_i, .preload_data_i,
    .oe_pin_n_i, .in_i, .io_out_o, .io_oe_o);

// >>> verification/amc_output_macrocells_tb.sv
/* Bench: cell 0 bypass, cell 1 clocked by input 1, cell 2 set/clear.
   Assumes the checker is bound by its own file. */
module amc_output_macrocells_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import amc_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, oe_pin_n_i = 1'b0;
    logic ce_i = 1'b1, preload_i = 1'b0;
    logic [NUM_CELLS-1:0]  preload_data_i = '0;
    logic [NUM_INPUTS-1:0] in_i = '0;
    logic [NUM_CELLS-1:0]  io_out_o, io_oe_o, pin;
    logic [FUSE_WIDTH-1:0] fuse_i;
    int fail_count = 0, compares = 0;
    int tix [8] = '{0, 7, 8, 14, 15, 20, 21, 23};
    logic [59:0] tv [8] = '{60'h1, 60'h0, 60'h1, 60'h2, 60'h0, 60'h4,
                            60'h8, 60'h0};
    initial forever #2 clk_i = ~clk_i;
    amc_output_macrocells u_amc_output_macrocells (.clk_i, .rstn_i,
        .ce_i, .in_i, .io_in_i(pin), .io_out_o, .io_oe_o,
        .oe_pin_n_i, .preload_i, .preload_data_i, .fuse_i,
        .pol_i(10'h007), .bypass_i(10'h001));
    amc_pin_model u_amc_pin_model (.clk_i, .rstn_i, .drv_i(io_out_o),
        .oe_i(io_oe_o), .pin_o(pin));
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input string s, input logic [9:0] e, g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // Clock term held three cycles: only pulses under one cycle may be missed
    task automatic pulse();
        in_i[1] = 1'b1;
        step(3);
        in_i[1] = 1'b0;
        step(5);
    endtask
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        test_done();
    end
    initial
    begin
        for (int i = 0; i < 80; i++)
            fuse_i[i*60 +: 60] = (60'h1 << 30) | 60'h1;
        for (int i = 0; i < 8; i++)
            fuse_i[tix[i]*60 +: 60] = tv[i];
        step(3);
        rstn_i = 1'b1;
        step(3);
        in_i[0] = 1'b1;
        step(5);
        check("bypass high", 10'h001, io_out_o & 10'h003);
        in_i[0] = 1'b0;
        step(5);
        check("bypass low", 10'h000, io_out_o & 10'h003);
        $display("test bypass done");
        in_i[0] = 1'b1;
        pulse();
        check("capture", 10'h003, io_out_o & 10'h003);
        in_i[0] = 1'b0;
        step(5);
        check("hold", 10'h002, io_out_o & 10'h003);
        pulse();
        check("capture low", 10'h000, io_out_o & 10'h003);
        $display("test clocked done");
        in_i[3] = 1'b1;
        step(6);
        check("preset", 10'h004, io_out_o & 10'h004);
        in_i[2] = 1'b1;
        step(6);
        check("reset wins", 10'h000, io_out_o & 10'h004);
        $display("test set clear done");
        in_i[3:2] = 2'b00;
        step(5);
        preload_data_i = 10'h004;
        preload_i = 1'b1;
        step(6);
        check("preload", 10'h004, io_out_o & 10'h006);
        preload_i = 1'b0;
        step(5);
        check("preload held", 10'h004, io_out_o & 10'h006);
        $display("test preload done");
        oe_pin_n_i = 1'b1;
        step(5);
        check("oe off", 10'h000, io_oe_o);
        oe_pin_n_i = 1'b0;
        step(5);
        check("oe on", 10'h007, io_oe_o);
        $display("test enable done");
        ce_i = 1'b0;
        in_i[0] = 1'b1;
        step(5);
        check("frozen", 10'h000, io_out_o & 10'h001);
        ce_i = 1'b1;
        step(5);
        check("resumed", 10'h001, io_out_o & 10'h001);
        $display("test clock enable done");
        test_done();
    end
endmodule
